// >>> sbtcc_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "sbtcc_cfg.svh"
module sbtcc_core
   import sbtcc_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   input  wire logic [5:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [3:0]  byteenable,
   input  wire logic [31:0] writedata,
   output var  logic [31:0] readdata,
   output var  logic        waitrequest,
   input  wire logic        external_count_pin,
   input  wire logic        capture_input_pin,
   input  wire logic        comparator_out,
   input  wire logic        capture_from_comparator,
   input  wire logic [3:0]  irq_taken,
   output var  logic [3:0]  irq_req,
   output var  logic [1:0]  wave_out_pins,
   output var  logic        count_at_top,
   output var  logic        count_at_bottom
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0]  ctrl_a_reg;
   logic [7:0]  ctrl_b_reg;
   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic [7:0]  temp_reg;
   logic [15:0] capture_reg;
   logic [3:0]  flag_reg;
   logic [3:0]  flag_next;
   logic [3:0]  mask_reg;
   sbtcc_dir_t  dir_reg;
   sbtcc_dir_t  dir_next;
   logic [9:0]  presc_reg;
   logic        ext_prev_reg;
   logic [`SBTCC_NC_DEPTH-1:0] nc_pipe_reg;
   logic        cap_lvl_reg;
   logic        cap_prev_reg;
   logic        block_reg;
   logic [15:0] cmp_buf_reg [2];
   logic [15:0] cmp_reg [2];
   logic [1:0]  match_vec;
   logic [7:0]  rd_byte;
   logic        tick;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire accept   = (read | write) & ~waitrequest;
   wire rd_take  = read & waitrequest;
   wire wr_acc   = write & accept & byteenable[0];
   wire [7:0] wd = writedata[7:0];
   wire w_ctrl_a = wr_acc && (address == `SBTCC_OFS_CTRL_A);
   wire w_ctrl_b = wr_acc && (address == `SBTCC_OFS_CTRL_B);
   wire w_cnt_lo = wr_acc && (address == `SBTCC_OFS_CNT_LO);
   wire w_cap_lo = wr_acc && (address == `SBTCC_OFS_CAP_LO);
   wire w_flag   = wr_acc && (address == `SBTCC_OFS_FLAG);
   wire w_mask   = wr_acc && (address == `SBTCC_OFS_MASK);
   wire w_cmp_lo [2];
   assign w_cmp_lo[0] = wr_acc && (address == `SBTCC_OFS_CMPA_LO);
   assign w_cmp_lo[1] = wr_acc && (address == `SBTCC_OFS_CMPB_LO);
   wire w_any_hi = wr_acc && ((address == `SBTCC_OFS_CNT_HI) ||
                   (address == `SBTCC_OFS_CMPA_HI) ||
                   (address == `SBTCC_OFS_CMPB_HI) ||
                   (address == `SBTCC_OFS_CAP_HI));
   wire r_cnt_lo = rd_take && (address == `SBTCC_OFS_CNT_LO);
   wire r_cap_lo = rd_take && (address == `SBTCC_OFS_CAP_LO);

   // ------------------------------------------------------------
   // Mode and top
   // ------------------------------------------------------------
   wire sbtcc_mode_t mode = sbtcc_decode({ctrl_b_reg[4:3], ctrl_a_reg[1:0]});
   wire [15:0] top_val  = mode.top_cmpa ? cmp_reg[0] :
                          mode.top_cap  ? capture_reg : mode.fixed_top;
   wire buffered  = mode.dual | mode.fast;
   wire at_top    = (count_reg == top_val);
   wire at_bottom = (count_reg == `SBTCC_RST_WORD);
   wire upd_point = tick & (mode.upd_bottom ? at_bottom : at_top);
   wire [15:0] cnt_inc = count_reg + 16'h0001;
   wire [15:0] cnt_dec = count_reg - 16'h0001;

   // ------------------------------------------------------------
   // Tick source
   // ------------------------------------------------------------
   wire [2:0] cs    = ctrl_b_reg[2:0];
   wire ext_rise    = external_count_pin & ~ext_prev_reg;
   wire ext_fall    = ~external_count_pin & ext_prev_reg;
   always_comb begin
      case (cs)
         3'h0:    tick = 1'b0;
         3'h1:    tick = 1'b1;
         3'h2:    tick = &presc_reg[2:0];
         3'h3:    tick = &presc_reg[5:0];
         3'h4:    tick = &presc_reg[7:0];
         3'h5:    tick = &presc_reg[9:0];
         3'h6:    tick = ext_fall;
         default: tick = ext_rise;
      endcase
   end

   // ------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------
   always_comb begin
      count_next = count_reg;
      dir_next   = dir_reg;
      if (w_cnt_lo) begin
         count_next = {temp_reg, wd};
      end else if (tick) begin
         if (mode.dual) begin
            if (dir_reg == DIR_UP) begin
               if (count_reg >= top_val) begin
                  dir_next   = DIR_DOWN;
                  count_next = cnt_dec;
               end else begin
                  count_next = cnt_inc;
               end
            end else if (at_bottom) begin
               dir_next   = DIR_UP;
               count_next = cnt_inc;
            end else begin
               count_next = cnt_dec;
            end
         end else if ((mode.fast | mode.ctc) && at_top) begin
            count_next = `SBTCC_RST_WORD;
         end else begin
            count_next = cnt_inc;
         end
      end
   end

   // Wrap point per mode family
   wire wrap_evt = tick & ~w_cnt_lo &
                   ((mode.dual & at_bottom & (dir_reg == DIR_DOWN)) |
                    (mode.fast & at_top) |
                    (~buffered & (count_reg == `SBTCC_MAX16)));

   // ------------------------------------------------------------
   // Capture path
   // ------------------------------------------------------------
   wire cap_src   = capture_from_comparator ? comparator_out : capture_input_pin;
   wire nc_all1   = &nc_pipe_reg;
   wire nc_all0   = ~|nc_pipe_reg;
   // Filter adds latency so short spikes never reach the edge detector
   wire cap_lvl_next = ctrl_b_reg[`SBTCC_CB_NC] ?
                       (nc_all1 ? 1'b1 : nc_all0 ? 1'b0 : cap_lvl_reg) :
                       nc_pipe_reg[0];
   wire cap_edge  = ctrl_b_reg[`SBTCC_CB_EDGE] ? (cap_lvl_reg & ~cap_prev_reg) :
                                                 (~cap_lvl_reg & cap_prev_reg);
   // Capture register doubles as top, so events are ignored then
   wire cap_evt   = cap_edge & ~mode.top_cap;

   // ------------------------------------------------------------
   // Flags
   // ------------------------------------------------------------
   wire [3:0] flag_set = {cap_evt, match_vec, wrap_evt};
   wire [3:0] flag_clr = (w_flag ? wd[3:0] : 4'h0) | irq_taken;
   // Set beats clear in the same cycle
   assign flag_next = (flag_reg & ~flag_clr) | flag_set;

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   always_comb begin
      case (address)
         `SBTCC_OFS_CTRL_A:  rd_byte = ctrl_a_reg;
         `SBTCC_OFS_CTRL_B:  rd_byte = ctrl_b_reg;
         `SBTCC_OFS_CNT_LO:  rd_byte = count_reg[7:0];
         `SBTCC_OFS_CNT_HI:  rd_byte = temp_reg;
         `SBTCC_OFS_CMPA_LO: rd_byte = cmp_buf_reg[0][7:0];
         `SBTCC_OFS_CMPA_HI: rd_byte = cmp_buf_reg[0][15:8];
         `SBTCC_OFS_CMPB_LO: rd_byte = cmp_buf_reg[1][7:0];
         `SBTCC_OFS_CMPB_HI: rd_byte = cmp_buf_reg[1][15:8];
         `SBTCC_OFS_CAP_LO:  rd_byte = capture_reg[7:0];
         `SBTCC_OFS_CAP_HI:  rd_byte = temp_reg;
         `SBTCC_OFS_FLAG:    rd_byte = {4'h0, flag_reg};
         `SBTCC_OFS_MASK:    rd_byte = {4'h0, mask_reg};
         default:            rd_byte = `SBTCC_RST_BYTE;
      endcase
   end

   // ------------------------------------------------------------
   // Bus slave and registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         waitrequest <= 1'b1;
         readdata    <= 32'h0000_0000;
      end else begin
         waitrequest <= ~((read | write) & waitrequest);
         if (rd_take) readdata <= {24'h00_0000, rd_byte};
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_a_reg  <= `SBTCC_RST_BYTE;
         ctrl_b_reg  <= `SBTCC_RST_BYTE;
         temp_reg    <= `SBTCC_RST_BYTE;
         mask_reg    <= 4'h0;
         flag_reg    <= 4'h0;
         irq_req     <= 4'h0;
         capture_reg <= `SBTCC_RST_WORD;
      end else begin
         if (w_ctrl_a) ctrl_a_reg <= wd;
         if (w_ctrl_b) ctrl_b_reg <= wd;
         if (w_mask)   mask_reg <= wd[3:0];
         flag_reg <= flag_next;
         irq_req  <= flag_next & mask_reg;
         if (w_any_hi) begin
            temp_reg <= wd;
         end else if (r_cnt_lo) begin
            temp_reg <= count_reg[15:8];
         end else if (r_cap_lo) begin
            temp_reg <= capture_reg[15:8];
         end
         if (w_cap_lo && mode.top_cap) begin
            capture_reg <= {temp_reg, wd};
         end else if (cap_evt) begin
            capture_reg <= count_reg;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         count_reg       <= `SBTCC_RST_WORD;
         dir_reg         <= DIR_UP;
         presc_reg       <= 10'h000;
         ext_prev_reg    <= 1'b0;
         block_reg       <= 1'b0;
         nc_pipe_reg     <= '0;
         cap_lvl_reg     <= 1'b0;
         cap_prev_reg    <= 1'b0;
         count_at_top    <= 1'b0;
         count_at_bottom <= 1'b1;
      end else begin
         count_reg       <= count_next;
         dir_reg         <= dir_next;
         presc_reg       <= presc_reg + 10'h001;
         ext_prev_reg    <= external_count_pin;
         // A software write hides the match on the next tick
         block_reg       <= w_cnt_lo | (block_reg & ~tick);
         nc_pipe_reg     <= {nc_pipe_reg[`SBTCC_NC_DEPTH-2:0], cap_src};
         cap_lvl_reg     <= cap_lvl_next;
         cap_prev_reg    <= cap_lvl_reg;
         count_at_top    <= (count_next == top_val);
         count_at_bottom <= (count_next == `SBTCC_RST_WORD);
      end
   end

   // ------------------------------------------------------------
   // Compare channels
   // ------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_cmp
         wire [1:0] com    = ctrl_a_reg[7-2*ch -: 2];
         wire       no_pwm = (ch == 0) && mode.top_cmpa && buffered;
         assign match_vec[ch] = tick & ~block_reg &
                                (count_reg == cmp_reg[ch]);
         logic wave_next;
         always_comb begin
            wave_next = wave_out_pins[ch];
            if (com == 2'h0) begin
               wave_next = 1'b0;
            end else if (~buffered || no_pwm) begin
               if (match_vec[ch]) begin
                  case (com)
                     2'h1:    wave_next = ~wave_out_pins[ch];
                     2'h2:    wave_next = no_pwm ? 1'b0 : 1'b0;
                     default: wave_next = no_pwm ? 1'b0 : 1'b1;
                  endcase
               end
            end else if (mode.fast) begin
               if (match_vec[ch]) begin
                  wave_next = com[0];
               end else if (tick && at_top) begin
                  wave_next = ~com[0];
               end
            end else if (match_vec[ch]) begin
               wave_next = (dir_reg == DIR_UP) ? com[0] : ~com[0];
            end
         end

         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               cmp_buf_reg[ch]   <= `SBTCC_RST_WORD;
               cmp_reg[ch]       <= `SBTCC_RST_WORD;
               wave_out_pins[ch] <= 1'b0;
            end else begin
               if (w_cmp_lo[ch]) cmp_buf_reg[ch] <= {temp_reg, wd};
               if (~buffered || upd_point) begin
                  cmp_reg[ch] <= cmp_buf_reg[ch];
               end
               wave_out_pins[ch] <= wave_next;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   wire [7:0]  cnt_hi   = count_reg[15:8];
   wire [15:0] cmpa_act = cmp_reg[0];
   wire normal_mode     = ~buffered & ~mode.ctc;

   property p_stop;
      (cs == 3'h0) && !w_cnt_lo |=> count_reg == $past(count_reg);
   endproperty
   a_stop: assert property (p_stop) else $error("counter moved while stopped");
   property p_write_wins;
      w_cnt_lo |=> count_reg == {$past(temp_reg), $past(wd)};
   endproperty
   a_write_wins: assert property (p_write_wins) else $error("counter write lost");
   property p_latch_on_low;
      r_cnt_lo && !w_any_hi |=> temp_reg == $past(cnt_hi);
   endproperty
   a_latch_on_low: assert property (p_latch_on_low) else $error("latch not loaded");
   property p_inc;
      tick && !w_cnt_lo && normal_mode |=> count_reg == $past(cnt_inc);
   endproperty
   a_inc: assert property (p_inc) else $error("normal mode did not step");
   property p_match_flag;
      match_vec[0] |=> flag_reg[1];
   endproperty
   a_match_flag: assert property (p_match_flag) else $error("match flag missing");
   property p_ack_clear;
      irq_taken[1] && !match_vec[0] |=> !flag_reg[1];
   endproperty
   a_ack_clear: assert property (p_ack_clear) else $error("flag not cleared");
   property p_capture;
      cap_evt && !w_cap_lo |=> capture_reg == $past(count_reg);
   endproperty
   a_capture: assert property (p_capture) else $error("capture value wrong");
   property p_top_buffer;
      buffered && mode.top_cmpa && !upd_point |=> cmpa_act == $past(cmpa_act);
   endproperty
   a_top_buffer: assert property (p_top_buffer) else $error("top changed mid period");
   property p_filter;
      ctrl_b_reg[`SBTCC_CB_NC] && !nc_all1 && !nc_all0 |=> $stable(cap_lvl_reg);
   endproperty
   a_filter: assert property (p_filter) else $error("filter passed a spike");
   property p_bus_ack;
      (read || write) && waitrequest |=> !waitrequest;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("bus answer late");
   property p_wrap_cov;
      wrap_evt ##1 flag_reg[0];
   endproperty
   c_wrap: cover property (p_wrap_cov);
   c_capture: cover property (cap_evt ##1 flag_reg[3]);
   c_match_b: cover property (match_vec[1] && buffered);
endmodule
`default_nettype wire

// >>> sbtcc_cfg.svh
`ifndef SBTCC_CFG_SVH
`define SBTCC_CFG_SVH

// Register byte offsets
`define SBTCC_OFS_CTRL_A   6'h00
`define SBTCC_OFS_CTRL_B   6'h04
`define SBTCC_OFS_CNT_LO   6'h08
`define SBTCC_OFS_CNT_HI   6'h0c
`define SBTCC_OFS_CMPA_LO  6'h10
`define SBTCC_OFS_CMPA_HI  6'h14
`define SBTCC_OFS_CMPB_LO  6'h18
`define SBTCC_OFS_CMPB_HI  6'h1c
`define SBTCC_OFS_CAP_LO   6'h20
`define SBTCC_OFS_CAP_HI   6'h24
`define SBTCC_OFS_FLAG     6'h28
`define SBTCC_OFS_MASK     6'h2c

// Field positions
`define SBTCC_CB_NC        7
`define SBTCC_CB_EDGE      6
`define SBTCC_FLG_WRAP     0
`define SBTCC_FLG_CAP      3

// Reset values and fixed counts
`define SBTCC_RST_BYTE     8'h00
`define SBTCC_RST_WORD     16'h0000
`define SBTCC_MAX16        16'hffff
`define SBTCC_TOP8         16'h00ff
`define SBTCC_TOP9         16'h01ff
`define SBTCC_TOP10        16'h03ff
`define SBTCC_NC_DEPTH     4
`endif

// >>> sbtcc_pkg.sv
`default_nettype none
`include "sbtcc_cfg.svh"
package sbtcc_pkg;
   typedef enum {DIR_UP, DIR_DOWN} sbtcc_dir_t;

   typedef struct packed {
      logic        dual;
      logic        fast;
      logic        ctc;
      logic        upd_bottom;
      logic        top_cmpa;
      logic        top_cap;
      logic [15:0] fixed_top;
   } sbtcc_mode_t;

   function automatic sbtcc_mode_t sbtcc_decode(input logic [3:0] w);
      sbtcc_mode_t m;
      m = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, `SBTCC_MAX16};
      case (w)
         4'h1: begin m.dual = 1'b1; m.fixed_top = `SBTCC_TOP8; end
         4'h2: begin m.dual = 1'b1; m.fixed_top = `SBTCC_TOP9; end
         4'h3: begin m.dual = 1'b1; m.fixed_top = `SBTCC_TOP10; end
         4'h4: begin m.ctc = 1'b1; m.top_cmpa = 1'b1; end
         4'h5: begin m.fast = 1'b1; m.fixed_top = `SBTCC_TOP8; end
         4'h6: begin m.fast = 1'b1; m.fixed_top = `SBTCC_TOP9; end
         4'h7: begin m.fast = 1'b1; m.fixed_top = `SBTCC_TOP10; end
         4'h8: begin m.dual = 1'b1; m.upd_bottom = 1'b1; m.top_cap = 1'b1; end
         4'h9: begin m.dual = 1'b1; m.upd_bottom = 1'b1; m.top_cmpa = 1'b1; end
         4'ha: begin m.dual = 1'b1; m.top_cap = 1'b1; end
         4'hb: begin m.dual = 1'b1; m.top_cmpa = 1'b1; end
         4'hc: begin m.ctc = 1'b1; m.top_cap = 1'b1; end
         4'he: begin m.fast = 1'b1; m.top_cap = 1'b1; end
         4'hf: begin m.fast = 1'b1; m.top_cmpa = 1'b1; end
         default: m.fixed_top = `SBTCC_MAX16;
      endcase
      return m;
   endfunction
endpackage
`default_nettype wire

// >>> sbtcc_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module sbtcc_cpu_model (
   input  wire logic        clk_sys,
   input  wire logic        waitrequest,
   input  wire logic [31:0] readdata,
   output var  logic [5:0]  address,
   output var  logic        read,
   output var  logic        write,
   output var  logic [3:0]  byteenable,
   output var  logic [31:0] writedata,
   output var  logic        hang
);
   // ----
   // Processor side of the register bus
   // ----
   initial begin
      address = 6'h00;
      read = 1'b0;
      write = 1'b0;
      byteenable = 4'h1;
      writedata = 32'h00000000;
      hang = 1'b0;
   end

   task automatic xfer(input logic rnw, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      int n;
      @(posedge clk_sys);
      address <= a;
      writedata <= {24'h000000, d};
      read <= rnw;
      write <= !rnw;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      // Flag a dead slave instead of hanging
      if (n >= 50) hang <= 1'b1;
      q = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] q;
      xfer(1'b0, a, d, q);
   endtask

   task automatic rd(input logic [5:0] a, output logic [7:0] q);
      xfer(1'b1, a, 8'h00, q);
   endtask

   // High byte to latch first; callers only write the counter while stopped
   task automatic wr16(input logic [5:0] a, input logic [15:0] v);
      wr(a + 6'h04, v[15:8]);
      wr(a, v[7:0]);
   endtask

   task automatic rd16(input logic [5:0] a, output logic [15:0] v);
      rd(a, v[7:0]);
      rd(a + 6'h04, v[15:8]);
   endtask
endmodule
`default_nettype wire

// >>> sbtcc_core_bench.sv
`timescale 1ns/100ps
`default_nettype none
module sbtcc_core_bench;
   logic        clk_sys = 1'b0;
   logic        arst_n = 1'b0;
   logic        ext_pin = 1'b0;
   logic        cap_pin = 1'b0;
   logic [3:0]  irq_taken = 4'h0;
   logic [5:0]  address;
   logic        read;
   logic        write;
   logic [3:0]  byteenable;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        hang;
   logic [3:0]  irq_req;
   logic [1:0]  wave_out_pins;
   logic        count_at_top;
   logic        count_at_bottom;
   int          fail_count = 0;
   int          check_count = 0;
   logic        cmp_out = 1'b0;
   logic        cmp_sel = 1'b0;
   int          n = 0;
   int          m = 0;
   logic [7:0]  b;
   logic [15:0] w;
   logic [5:0]  ra [4] = '{6'h00, 6'h04, 6'h2c, 6'h30};
   logic [7:0]  rw [4] = '{8'hc1, 8'hc0, 8'h0f, 8'h55};
   logic [7:0]  re [4] = '{8'hc1, 8'hc0, 8'h0f, 8'h00};

   sbtcc_core i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .address(address), .read(read),
      .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .external_count_pin(ext_pin), .capture_input_pin(cap_pin),
      .comparator_out(cmp_out), .capture_from_comparator(cmp_sel), .irq_taken(irq_taken),
      .irq_req(irq_req), .wave_out_pins(wave_out_pins), .count_at_top(count_at_top),
      .count_at_bottom(count_at_bottom));

   sbtcc_cpu_model i_cpu (.clk_sys(clk_sys), .waitrequest(waitrequest), .readdata(readdata),
      .address(address), .read(read), .write(write), .byteenable(byteenable),
      .writedata(writedata), .hang(hang));

   // ----
   // Checking helpers
   // ----
   always #5 clk_sys = ~clk_sys;

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic pin(input logic v, input int n);
      @(posedge clk_sys);
      cap_pin <= v;
      repeat (n) @(posedge clk_sys);
   endtask

   always @(posedge hang) begin
      fail_count++;
      close_out();
   end

   // ----
   // Main sequence
   // ----
   initial begin
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      chk(16'(count_at_bottom), 16'h0001);
      i_cpu.rd16(6'h08, w);
      chk(w, 16'h0000);
      i_cpu.rd(6'h2c, b);
      chk(16'(b), 16'h0000);
      for (int i = 0; i < 4; i++) begin
         i_cpu.wr(ra[i], rw[i]);
         i_cpu.rd(ra[i], b);
         chk(16'(b), 16'(re[i]));
      end
      i_cpu.wr(6'h00, 8'h00);
      i_cpu.wr16(6'h08, 16'h1234);
      i_cpu.wr16(6'h18, 16'h0102);
      repeat (20) @(posedge clk_sys);
      i_cpu.rd16(6'h08, w);
      chk(w, 16'h1234);
      i_cpu.rd16(6'h18, w);
      chk(w, 16'h0102);
      // Capture on rising edge, filter off, counter stopped
      i_cpu.wr(6'h04, 8'h40);
      pin(1'b1, 4);
      i_cpu.rd(6'h28, b);
      chk(16'(b), 16'h0008);
      i_cpu.rd16(6'h20, w);
      chk(w, 16'h1234);
      i_cpu.wr(6'h28, 8'h08);
      i_cpu.rd(6'h28, b);
      chk(16'(b), 16'h0000);
      // Short glitch must not pass the filter
      pin(1'b0, 2);
      i_cpu.wr(6'h04, 8'hc0);
      pin(1'b1, 2);
      pin(1'b0, 10);
      i_cpu.rd(6'h28, b);
      chk(16'(b), 16'h0000);
      pin(1'b1, 10);
      i_cpu.rd(6'h28, b);
      chk(16'(b), 16'h0008);
      i_cpu.wr(6'h2c, 8'h08);
      repeat (2) @(posedge clk_sys);
      chk(16'(irq_req), 16'h0008);
      irq_taken <= 4'ha;
      @(posedge clk_sys);
      irq_taken <= 4'h0;
      repeat (2) @(posedge clk_sys);
      chk(16'(irq_req), 16'h0000);
      // Capture from the comparator output, filter still on
      cmp_sel <= 1'b1;
      repeat (6) @(posedge clk_sys);
      cmp_out <= 1'b1;
      repeat (10) @(posedge clk_sys);
      i_cpu.rd(6'h28, b);
      chk(16'(b), 16'h0008);
      cmp_sel <= 1'b0;
      pin(1'b0, 2);
      // External pin, rising edges
      i_cpu.wr(6'h04, 8'h07);
      repeat (5) begin
         @(posedge clk_sys);
         ext_pin <= 1'b1;
         repeat (2) @(posedge clk_sys);
         ext_pin <= 1'b0;
         repeat (2) @(posedge clk_sys);
      end
      i_cpu.wr(6'h04, 8'h00);
      i_cpu.rd16(6'h08, w);
      chk(w, 16'h1239);
      // Normal mode wrap and compare A match
      i_cpu.wr(6'h28, 8'h0f);
      i_cpu.wr16(6'h10, 16'hfff8);
      i_cpu.wr16(6'h08, 16'hfff0);
      i_cpu.wr(6'h00, 8'h40);
      i_cpu.wr(6'h04, 8'h01);
      b = 8'h00;
      for (int i = 0; i < 30 && b[0] !== 1'b1; i++) i_cpu.rd(6'h28, b);
      chk(16'(b), 16'h0003);
      chk(16'(wave_out_pins), 16'h0001);
      // Clear on compare A top
      i_cpu.wr(6'h04, 8'h00);
      i_cpu.wr16(6'h10, 16'h0010);
      i_cpu.wr16(6'h08, 16'h0000);
      i_cpu.wr(6'h04, 8'h09);
      for (int i = 0; i < 60 && count_at_top !== 1'b1; i++) @(posedge clk_sys);
      chk(16'(count_at_top), 16'h0001);
      i_cpu.wr(6'h04, 8'h08);
      i_cpu.rd16(6'h08, w);
      chk(16'(w <= 16'h0010), 16'h0001);
      // Fast mode, compare A as top: a new top waits for the wrap
      i_cpu.wr(6'h04, 8'h18);
      i_cpu.wr(6'h00, 8'h03);
      i_cpu.wr16(6'h08, 16'h0000);
      i_cpu.wr16(6'h10, 16'h0020);
      i_cpu.wr(6'h04, 8'h19);
      for (n = 0; n < 60 && count_at_top !== 1'b1; n++) @(posedge clk_sys);
      chk(16'(n < 24), 16'h0001);
      @(posedge clk_sys);
      for (m = 0; m < 60 && count_at_top !== 1'b1; m++) @(posedge clk_sys);
      chk(16'(m > 24 && m < 40), 16'h0001);
      i_cpu.wr(6'h04, 8'h18);
      // Reset in mid-run
      arst_n <= 1'b0;
      @(posedge clk_sys);
      chk(16'({irq_req, wave_out_pins, count_at_top, count_at_bottom}), 16'h0001);
      arst_n <= 1'b1;
      i_cpu.rd16(6'h10, w);
      chk(w, 16'h0000);
      i_cpu.rd(6'h00, b);
      chk(16'(b), 16'h0000);
      close_out();
   end
endmodule
`default_nettype wire
